// ### design/urs_consts.svh
// register offsets, field positions, reset values of the receive status block
// Behaviour
// - address detect ignored outside nine-bit mode
// - address character needs ninth bit set
// - idle flag one only while receiver idle
// - parity flag follows head buffered character
// - framing flag follows head buffered character
// - overrun sets on arrival into full buffer
// - writing zero over a set overrun clears it, flushes buffer, shifter
// - data available while buffer holds characters
// - four-character buffer loaded when reception completes
`ifndef URS_CONSTS_SVH
`define URS_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define URS_OFS_STATUS  3'h0
`define URS_OFS_MODE    3'h1
`define URS_OFS_RXDATA  3'h2
`define URS_OFS_IRQSTAT 3'h3
`define URS_OFS_IRQMASK 3'h4

// ****************************************
// status register fields
// ****************************************
`define URS_BIT_ADDREN  5
`define URS_BIT_IDLE    4
`define URS_BIT_PARERR  3
`define URS_BIT_FRMERR  2
`define URS_BIT_OVRERR  1
`define URS_BIT_AVAIL   0

// ****************************************
// character modes
// ****************************************
`define URS_MODE_8N     2'h0
`define URS_MODE_8E     2'h1
`define URS_MODE_8O     2'h2
`define URS_MODE_9N     2'h3

// ****************************************
// interrupt status fields
// ****************************************
`define URS_IRQ_RXCHAR  0
`define URS_IRQ_OVERRUN 1
`define URS_IRQ_PARITY  2
`define URS_IRQ_FRAMING 3

// ****************************************
// reset values
// ****************************************
`define URS_RST_ADDREN  1'h0
`define URS_RST_MODE    2'h0
`define URS_RST_IRQMASK 4'h0
`define URS_RST_DATA    16'h0000

// ****************************************
// defaults
// ****************************************
`define URS_DEF_DEPTH      4
`define URS_DEF_BIT_CYCLES 16

`endif

// ### design/urs_pkg.sv
// types shared by the receive status block
package urs_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_DATA,
    S_PARITY,
    S_STOP
  } urs_state_type;

  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } urs_bus_type;

  typedef struct packed {
    logic       parErr;
    logic       frmErr;
    logic [8:0] data;
  } urs_entry_type;

endpackage

// ### design/urs_rx_status.sv
// receiver with status flags, address detect, four-deep buffer and interrupt
`timescale 1ns/1ns
`include "urs_consts.svh"

module urs_rx_status #(
  parameter int DEPTH      = `URS_DEF_DEPTH,
  parameter int BIT_CYCLES = `URS_DEF_BIT_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire urs_pkg::urs_bus_type busReq,
  output logic [15:0]              rdData,
  input  wire logic                rxLine,
  output logic                     irq
);
  import urs_pkg::*;

  // ****************************************
  // sizes and elaboration checks
  // ****************************************
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [PW:0]   FULL_CNT  = (PW + 1)'(DEPTH);
  localparam logic [CW-1:0] BIT_LAST  = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2 - 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || BIT_CYCLES < 4) begin : g_bad_param
    $error("urs_rx_status: DEPTH must be a power of two >= 2, BIT_CYCLES >= 4");
  end

  // ****************************************
  // state
  // ****************************************
  urs_state_type state_q, state_d;
  logic [CW-1:0] cyc_q, cyc_d;
  logic [3:0]    bitIdx_q, bitIdx_d;
  logic [8:0]    shift_q, shift_d;
  logic          parBit_q, parBit_d;
  urs_entry_type mem_q [DEPTH];
  urs_entry_type mem_d [DEPTH];
  logic [PW-1:0] wrPtr_q, wrPtr_d;
  logic [PW-1:0] rdPtr_q, rdPtr_d;
  logic [PW:0]   cnt_q, cnt_d;
  logic          addrEn_q, addrEn_d;
  logic [1:0]    mode_q, mode_d;
  logic          ovrErr_q, ovrErr_d;
  logic [3:0]    ist_q, ist_d;
  logic [3:0]    imask_q, imask_d;
  logic [15:0]   rdData_q, rdData_d;
  logic          irq_q, irq_d;

  // ****************************************
  // combinational helpers
  // ****************************************
  logic          nineBit;
  logic          parOn;
  logic          doneEv;
  logic          keepChar;
  logic          full;
  logic          push;
  logic          pop;
  logic          ovfEv;
  logic          flush;
  logic          idleFlag;
  logic          headParErr;
  logic          headFrmErr;
  urs_entry_type entry;
  logic [3:0]    events;

  function automatic logic parityBad(input logic [7:0] d, input logic p, input logic odd);
    parityBad = ^d ^ p ^ odd;
  endfunction

  always_comb begin
    state_d  = state_q;
    cyc_d    = cyc_q;
    bitIdx_d = bitIdx_q;
    shift_d  = shift_q;
    parBit_d = parBit_q;
    mem_d    = mem_q;
    wrPtr_d  = wrPtr_q;
    rdPtr_d  = rdPtr_q;
    cnt_d    = cnt_q;
    addrEn_d = addrEn_q;
    mode_d   = mode_q;
    ovrErr_d = ovrErr_q;
    imask_d  = imask_q;
    rdData_d = `URS_RST_DATA;
    doneEv   = 1'b0;
    nineBit  = (mode_q == `URS_MODE_9N);
    parOn    = (mode_q == `URS_MODE_8E) || (mode_q == `URS_MODE_8O);
    idleFlag = (state_q == S_IDLE);
    full     = (cnt_q == FULL_CNT);
    headParErr = (cnt_q != '0) && mem_q[rdPtr_q].parErr;
    headFrmErr = (cnt_q != '0) && mem_q[rdPtr_q].frmErr;

    // receive sequencer, sampling mid-bit
    unique case (state_q)
      S_IDLE: begin
        if (!rxLine) begin
          state_d = S_START;
          cyc_d   = HALF_LAST;
        end
      end
      S_START: begin
        if (cyc_q != '0) begin
          cyc_d = cyc_q - 1'b1;
        end else if (rxLine) begin
          state_d = S_IDLE;                 // glitch, not a start bit
        end else begin
          state_d  = S_DATA;
          cyc_d    = BIT_LAST;
          bitIdx_d = 4'h0;
        end
      end
      S_DATA: begin
        if (cyc_q != '0) begin
          cyc_d = cyc_q - 1'b1;
        end else begin
          shift_d  = {rxLine, shift_q[8:1]};
          bitIdx_d = bitIdx_q + 4'h1;
          cyc_d    = BIT_LAST;
          if (bitIdx_q == (nineBit ? 4'h8 : 4'h7)) begin
            state_d = parOn ? S_PARITY : S_STOP;
          end
        end
      end
      S_PARITY: begin
        if (cyc_q != '0) begin
          cyc_d = cyc_q - 1'b1;
        end else begin
          parBit_d = rxLine;
          cyc_d    = BIT_LAST;
          state_d  = S_STOP;
        end
      end
      S_STOP: begin
        if (cyc_q != '0) begin
          cyc_d = cyc_q - 1'b1;
        end else begin
          doneEv  = 1'b1;
          state_d = S_IDLE;
        end
      end
    endcase

    // character as it leaves the shifter; 8-bit data sits in the top bits
    entry.data = nineBit ? shift_q : {1'b0, shift_q[8:1]};
    entry.parErr = parOn && parityBad(entry.data[7:0], parBit_q,
                                      mode_q == `URS_MODE_8O);
    entry.frmErr = !rxLine;

    // address mode only counts in nine-bit mode
    keepChar = !(addrEn_q && nineBit) || entry.data[8];
    ovfEv    = doneEv && keepChar && full;
    push     = doneEv && keepChar && !full;
    pop      = busReq.rd && (busReq.addr == `URS_OFS_RXDATA) && (cnt_q != '0);
    // a set in the same cycle wins, so no 1 to 0 edge and no flush
    flush    = busReq.wr && (busReq.addr == `URS_OFS_STATUS) &&
               !busReq.wdata[`URS_BIT_OVRERR] && ovrErr_q && !ovfEv;

    if (push) begin
      mem_d[wrPtr_q] = entry;
      wrPtr_d        = wrPtr_q + 1'b1;
    end
    if (pop) begin
      rdPtr_d = rdPtr_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end

    if (ovfEv) begin
      ovrErr_d = 1'b1;
    end else if (flush) begin
      ovrErr_d = 1'b0;
      wrPtr_d = '0;
      rdPtr_d = '0;
      cnt_d   = '0;
      state_d = S_IDLE;                     // abandons any half-shifted character
    end

    // register writes
    if (busReq.wr) begin
      unique case (busReq.addr)
        `URS_OFS_STATUS:  addrEn_d = busReq.wdata[`URS_BIT_ADDREN];
        `URS_OFS_MODE:    mode_d   = busReq.wdata[1:0];
        `URS_OFS_IRQMASK: imask_d  = busReq.wdata[3:0];
        default:          ;
      endcase
    end

    // register reads, answer stands only in the next cycle
    if (busReq.rd) begin
      unique case (busReq.addr)
        `URS_OFS_STATUS: begin
          rdData_d[`URS_BIT_ADDREN] = addrEn_q;
          rdData_d[`URS_BIT_IDLE]   = idleFlag;
          rdData_d[`URS_BIT_PARERR] = headParErr;
          rdData_d[`URS_BIT_FRMERR] = headFrmErr;
          rdData_d[`URS_BIT_OVRERR] = ovrErr_q;
          rdData_d[`URS_BIT_AVAIL]  = (cnt_q != '0);
        end
        `URS_OFS_MODE:    rdData_d[1:0] = mode_q;
        `URS_OFS_RXDATA:  rdData_d[8:0] = (cnt_q != '0) ? mem_q[rdPtr_q].data : 9'h000;
        `URS_OFS_IRQSTAT: rdData_d[3:0] = ist_q;
        `URS_OFS_IRQMASK: rdData_d[3:0] = imask_q;
        default:          ;
      endcase
    end

    // sticky events; a read clears, a new event in that cycle survives
    events = '0;
    events[`URS_IRQ_RXCHAR]  = push;
    events[`URS_IRQ_OVERRUN] = ovfEv;
    events[`URS_IRQ_PARITY]  = push && entry.parErr;
    events[`URS_IRQ_FRAMING] = push && entry.frmErr;
    ist_d = ((busReq.rd && busReq.addr == `URS_OFS_IRQSTAT) ? 4'h0 : ist_q) | events;
    irq_d = |(ist_d & imask_d);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q  <= S_IDLE;
      cyc_q    <= '0;
      bitIdx_q <= '0;
      shift_q  <= '0;
      parBit_q <= 1'b0;
      wrPtr_q  <= '0;
      rdPtr_q  <= '0;
      cnt_q    <= '0;
      addrEn_q <= `URS_RST_ADDREN;
      mode_q   <= `URS_RST_MODE;
      ovrErr_q <= 1'b0;
      ist_q    <= '0;
      imask_q  <= `URS_RST_IRQMASK;
      rdData_q <= `URS_RST_DATA;
      irq_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      cyc_q    <= cyc_d;
      bitIdx_q <= bitIdx_d;
      shift_q  <= shift_d;
      parBit_q <= parBit_d;
      wrPtr_q  <= wrPtr_d;
      rdPtr_q  <= rdPtr_d;
      cnt_q    <= cnt_d;
      addrEn_q <= addrEn_d;
      mode_q   <= mode_d;
      ovrErr_q <= ovrErr_d;
      ist_q    <= ist_d;
      imask_q  <= imask_d;
      rdData_q <= rdData_d;
      irq_q    <= irq_d;
    end
  end

  // buffer storage needs no reset, the count guards it
  always_ff @(posedge clk) begin
    mem_q <= mem_d;
  end

  assign rdData = rdData_q;
  assign irq    = irq_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic statusRd;
  assign statusRd = busReq.rd && (busReq.addr == `URS_OFS_STATUS);

  eight_bit_push_a: assert property (
    (doneEv && !nineBit && !full && !flush && !pop) |=> (cnt_q == $past(cnt_q) + 1'b1))
    else $error("character not buffered outside nine-bit mode");

  addr_reject_a: assert property (
    (doneEv && addrEn_q && nineBit && !entry.data[8] && !pop && !flush)
      |=> (cnt_q == $past(cnt_q)) && !ist_q[`URS_IRQ_RXCHAR])
    else $error("data character accepted in address mode");

  idle_flag_a: assert property (
    (statusRd && state_q != S_IDLE) |=> !rdData_q[`URS_BIT_IDLE])
    else $error("idle flag set while receiving");

  parity_head_a: assert property (
    statusRd |=> (rdData_q[`URS_BIT_PARERR] == $past(headParErr)))
    else $error("parity flag does not follow head character");

  framing_head_a: assert property (
    statusRd |=> (rdData_q[`URS_BIT_FRMERR] == $past(headFrmErr)))
    else $error("framing flag does not follow head character");

  overrun_set_a: assert property (
    ovfEv |=> ovrErr_q && (cnt_q == FULL_CNT || $past(pop)))
    else $error("overrun not flagged");

  overrun_clear_a: assert property (
    flush |=> !ovrErr_q && (cnt_q == '0) && (state_q == S_IDLE))
    else $error("overrun clear did not flush");

  avail_flag_a: assert property (
    statusRd |=> (rdData_q[`URS_BIT_AVAIL] == ($past(cnt_q) != '0)))
    else $error("data available flag wrong");

  depth_bound_a: assert property (
    (cnt_q <= FULL_CNT) && !(full && push))
    else $error("buffer count beyond depth");

endmodule

// ### tb/urs_rx_status_tb_top.sv
// self-checking bench for the receive status block
`timescale 1ns/1ns

module urs_rx_status_tb_top;
  import urs_pkg::*;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  urs_bus_type  busReq = '0;
  logic [15:0]  rdData;
  logic         rxLine;
  logic         irq;
  logic         go = 1'b0;
  logic [11:0]  frame = 12'h000;
  logic [3:0]   nBits = 4'h0;
  logic         busy;
  logic [15:0]  v;
  int           errorCnt = 0;
  int           checkCount = 0;

  always #20 clk = ~clk;

  urs_rx_status #(.DEPTH(4), .BIT_CYCLES(4)) urs_rx_status_inst (
    .clk(clk), .srst(srst), .busReq(busReq), .rdData(rdData), .rxLine(rxLine), .irq(irq));
  urs_tx_model #(.BIT_CYCLES(4)) urs_tx_model_inst (
    .clk(clk), .go(go), .frame(frame), .nBits(nBits), .line(rxLine), .busy(busy));

  // ****************************************
  // access tasks
  // ****************************************
  task automatic test_done;
    if (errorCnt == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrReg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq.addr  <= a;
    busReq.wdata <= d;
    busReq.wr    <= 1'b1;
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask

  task automatic rdReg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    busReq.addr <= a;
    busReq.rd   <= 1'b1;
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 d = rdData;
  endtask

  // parity even for mode 1, odd for mode 2; badPar flips it
  task automatic startChar(input logic [8:0] d, input logic [1:0] m, input logic badPar,
                           input logic badStop);
    logic [11:0] f;
    int          n;
    f = 12'hFFF;
    f[8:0] = {d[7:0], 1'b0};
    n = 10;
    if (m == 2'h3) begin
      f[9] = d[8];
      n = 11;
    end
    if (m == 2'h1 || m == 2'h2) begin
      f[9] = (^d[7:0]) ^ (m == 2'h2) ^ badPar;
      n = 11;
    end
    f[n-1] = ~badStop;
    @(posedge clk);
    frame <= f;
    nBits <= 4'(n);
    go    <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic waitChar;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (busy && k < 200);
    if (busy) begin
      errorCnt++;
      test_done;
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic sendChar(input logic [8:0] d, input logic [1:0] m, input logic bp,
                          input logic bs);
    startChar(d, m, bp, bs);
    waitChar;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rdReg(3'h0, v); check("status", v, 16'h0010);
    rdReg(3'h1, v); check("mode", v, 16'h0000);
    rdReg(3'h5, v); check("unmapped", v, 16'h0000);
    rdReg(3'h2, v); check("rxdata", v, 16'h0000);
    wrReg(3'h4, 16'h0001);
    startChar(9'h0A5, 2'h0, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    rdReg(3'h0, v); check("status", v, 16'h0000);
    waitChar;
    rdReg(3'h0, v); check("status", v, 16'h0011);
    check("irq", {15'h0000, irq}, 16'h0001);
    rdReg(3'h3, v); check("irqstat", v, 16'h0001);
    @(posedge clk);
    #1 check("irq", {15'h0000, irq}, 16'h0000);
    rdReg(3'h2, v); check("rxdata", v, 16'h00A5);
    rdReg(3'h0, v); check("status", v, 16'h0010);
    // parity flag follows the head character only
    wrReg(3'h4, 16'h0000);
    wrReg(3'h1, 16'h0001);
    sendChar(9'h003, 2'h1, 1'b1, 1'b0);
    sendChar(9'h007, 2'h1, 1'b0, 1'b0);
    rdReg(3'h0, v); check("status", v, 16'h0019);
    check("irq", {15'h0000, irq}, 16'h0000);
    rdReg(3'h3, v); check("irqstat", v, 16'h0005);
    rdReg(3'h2, v); check("rxdata", v, 16'h0003);
    rdReg(3'h0, v); check("status", v, 16'h0011);
    rdReg(3'h2, v); check("rxdata", v, 16'h0007);
    wrReg(3'h1, 16'h0002);
    sendChar(9'h0F0, 2'h2, 1'b0, 1'b0);
    rdReg(3'h0, v); check("status", v, 16'h0011);
    rdReg(3'h2, v); check("rxdata", v, 16'h00F0);
    // framing error on first of two characters
    wrReg(3'h1, 16'h0000);
    sendChar(9'h055, 2'h0, 1'b0, 1'b1);
    sendChar(9'h066, 2'h0, 1'b0, 1'b0);
    rdReg(3'h0, v); check("status", v, 16'h0015);
    rdReg(3'h2, v); check("rxdata", v, 16'h0055);
    rdReg(3'h0, v); check("status", v, 16'h0011);
    rdReg(3'h2, v); check("rxdata", v, 16'h0066);
    // fill four, fifth overruns
    for (int i = 0; i < 5; i++) begin
      sendChar(9'(i + 1), 2'h0, 1'b0, 1'b0);
      if (i == 3) begin
        rdReg(3'h0, v); check("status", v, 16'h0011);
      end
    end
    rdReg(3'h0, v); check("status", v, 16'h0013);
    // oldest of the four survives the overrun, flag stays sticky
    rdReg(3'h2, v); check("rxdata", v, 16'h0001);
    wrReg(3'h0, 16'h0002);
    rdReg(3'h0, v); check("status", v, 16'h0013);
    wrReg(3'h0, 16'h0000);
    rdReg(3'h0, v); check("status", v, 16'h0010);
    rdReg(3'h2, v); check("rxdata", v, 16'h0000);
    // clear stale char events so the dropped address char shows none
    rdReg(3'h3, v); check("irqstat", v, 16'h000B);
    // address detect in nine-bit mode, then outside it
    wrReg(3'h1, 16'h0003);
    wrReg(3'h0, 16'h0020);
    rdReg(3'h0, v); check("status", v, 16'h0030);
    sendChar(9'h012, 2'h3, 1'b0, 1'b0);
    sendChar(9'h134, 2'h3, 1'b0, 1'b0);
    rdReg(3'h0, v); check("status", v, 16'h0031);
    rdReg(3'h2, v); check("rxdata", v, 16'h0134);
    wrReg(3'h1, 16'h0000);
    sendChar(9'h012, 2'h0, 1'b0, 1'b0);
    rdReg(3'h2, v); check("rxdata", v, 16'h0012);
    test_done;
  end
endmodule

// ### tb/urs_tx_model.sv
// remote serial transmitter driving the receive line
`timescale 1ns/1ns

module urs_tx_model #(
  parameter int BIT_CYCLES = 4
) (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [11:0] frame,
  input  wire logic [3:0]  nBits,
  output logic             line,
  output logic             busy
);
  // ****************************************
  // bit shifter
  // ****************************************
  logic [11:0] shiftQ = 12'h000;
  int          bitLeftQ = 0;
  int          cycQ = 0;

  always_ff @(posedge clk) begin
    if (go) begin
      shiftQ   <= frame;
      bitLeftQ <= int'(nBits);
      cycQ     <= 0;
    end else if (bitLeftQ > 0) begin
      if (cycQ == BIT_CYCLES - 1) begin
        cycQ     <= 0;
        shiftQ   <= shiftQ >> 1;
        bitLeftQ <= bitLeftQ - 1;
      end else begin
        cycQ <= cycQ + 1;
      end
    end
  end

  // line marks high between frames, as a real idle transmitter does
  assign busy = bitLeftQ > 0;
  assign line = busy ? shiftQ[0] : 1'b1;
endmodule
